//--- core/dkwdt_pkg.sv
/*
 Constants, register offsets and field layout for the dual keyed watchdog timers.
 Assumes a single 100 MHz bridge clock and an asynchronous active-high bridge reset.
*/
// What this block does
// - Two independent identical timers; reset counts equal 8 s and 16 s.
// - An enabled timer decrements once per prescaler period until reloaded or zero.
// - At zero the timeout output asserts and the count holds until reload or reset.
// - Prescaler period is any power of two from 1 us to 32768 us.
// - Counter units are prescaler periods; expiry time is count times period.
// - Control register starts, stops, stores reload, or reloads from stored value.
// - Status register read returns the instantaneous counter value.
// - Arming needs the first key in the key lane alone; otherwise stays unarmed.
// - The arming write leaves counting, enable and prescaler untouched.
// - Commit needs the key lane with the second key, else nothing changes.
// - Commit with enable lane loads live and stored field; else live from stored.
// - Commit with both reload lanes loads counter and stored reload; else counter from stored.
// - Any second write disarms the control register, whatever lanes it selects.
// - Control reads are allowed anytime and never disturb the arm state.
// - Both timers' control and status registers sit in the control space.
package dkwdt_pkg;
	localparam int          CLK_MHZ      = 100;
	localparam int          BASE_TICK_US = 1;
	localparam int          US_CYCLES    = CLK_MHZ * BASE_TICK_US;
	localparam int          US_PER_S     = 1000000;
	localparam int          TIMER_NUM    = 2;
	localparam int          CNT_W        = 16;
	localparam int          RES_W        = 4;
	localparam int          PRE_W        = 15;
	localparam int          ADDR_W       = 2;
	// Register offsets: bit 1 selects the timer, bit 0 control or status
	localparam logic [1:0]  CTL0_OFS     = 2'h0;
	localparam logic [1:0]  STAT0_OFS    = 2'h1;
	localparam logic [1:0]  CTL1_OFS     = 2'h2;
	localparam logic [1:0]  STAT1_OFS    = 2'h3;
	// Byte lanes, lane 0 holds bits 31:24 (most significant byte)
	localparam int          LANE_KEY     = 0;
	localparam int          LANE_RESEN   = 1;
	localparam int          LANE_RELHI   = 2;
	localparam int          LANE_RELLO   = 3;
	localparam int          KEY_MSB      = 31;
	localparam int          KEY_LSB      = 24;
	localparam int          EN_BIT       = 23;
	localparam int          RES_LSB      = 16;
	localparam int          RELOAD_LSB   = 0;
	// Reset state
	localparam int          WD0_TIME_S   = 8;
	localparam int          WD1_TIME_S   = 16;
	localparam logic [3:0]  RST_RES      = 4'h9;
	localparam logic        RST_EN       = 1'b1;
	localparam logic [15:0] RST_COUNT0   = 16'((WD0_TIME_S * US_PER_S) >> RST_RES);
	localparam logic [15:0] RST_COUNT1   = 16'((WD1_TIME_S * US_PER_S) >> RST_RES);
endpackage

//--- core/dkwdt_top.sv
/*
 Dual keyed watchdog timers with their control and count status registers.
 Assumes register strobes and data come from bridge logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dkwdt_top import dkwdt_pkg::*; #(
	parameter logic [7:0] KEY_ARM    = 8'h5A,
	parameter logic [7:0] KEY_COMMIT = 8'hA5
) (
	// Clock and reset
	input  wire logic              core_clk_i,
	input  wire logic              rst_i,
	// Register access
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [3:0]        reg_lane_i,
	input  wire logic [31:0]       reg_wdata_i,
	output logic      [31:0]       reg_rdata_o,
	output logic                   reg_rvalid_o,
	// Timeout outputs
	output logic      [1:0]        timeout_o
);

	function automatic logic [PRE_W-1:0] pre_mask(input logic [RES_W-1:0] res);
		pre_mask = PRE_W'((16'h0001 << res) - 16'h0001);
	endfunction

	logic [6:0]       us_cnt_ff;
	logic             us_tick;
	logic [1:0]       armed_ff;
	logic [1:0]       en_ff;
	logic [RES_W-1:0] res_ff      [2];
	logic [1:0]       st_en_ff;
	logic [RES_W-1:0] st_res_ff   [2];
	logic [CNT_W-1:0] reload_ff   [2];
	logic [CNT_W-1:0] count_ff    [2];
	logic [CNT_W-1:0] nxt_count   [2];
	logic [PRE_W-1:0] pre_ff      [2];
	logic [1:0]       timeout_ff;
	logic [1:0]       wr_ctl;
	logic [1:0]       commit;
	logic [1:0]       step;
	logic [31:0]      rdata_ff;
	logic             rvalid_ff;
	logic             arm_ok;
	logic             key_ok;
	logic             lane_rel;

	// Microsecond base tick
	assign us_tick = (us_cnt_ff == 7'(US_CYCLES - 1));
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			us_cnt_ff <= 7'h00;
		end else if (us_tick) begin
			us_cnt_ff <= 7'h00;
		end else begin
			us_cnt_ff <= us_cnt_ff + 7'h01;
		end
	end

	// Key and lane decode
	assign arm_ok   = (reg_lane_i == 4'h1) && (reg_wdata_i[KEY_MSB:KEY_LSB] == KEY_ARM);
	assign key_ok   = reg_lane_i[LANE_KEY] && (reg_wdata_i[KEY_MSB:KEY_LSB] == KEY_COMMIT);
	assign lane_rel = reg_lane_i[LANE_RELHI] && reg_lane_i[LANE_RELLO];

	always_comb begin
		for (int i = 0; i < TIMER_NUM; i++) begin
			wr_ctl[i] = reg_wr_i && (reg_addr_i == (i == 0 ? CTL0_OFS : CTL1_OFS));
			commit[i] = wr_ctl[i] && armed_ff[i] && key_ok;
			step[i]   = en_ff[i] && us_tick && (pre_ff[i] == pre_mask(res_ff[i]));
		end
	end

	// Arm state
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			armed_ff <= 2'h0;
		end else begin
			for (int i = 0; i < TIMER_NUM; i++) begin
				if (wr_ctl[i]) begin
					armed_ff[i] <= !armed_ff[i] && arm_ok;
				end
			end
		end
	end

	// Stored control fields and live prescaler enable and resolution
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < TIMER_NUM; i++) begin
				en_ff[i]     <= RST_EN;
				res_ff[i]    <= RST_RES;
				st_en_ff[i]  <= RST_EN;
				st_res_ff[i] <= RST_RES;
			end
			reload_ff[0] <= RST_COUNT0;
			reload_ff[1] <= RST_COUNT1;
		end else begin
			for (int i = 0; i < TIMER_NUM; i++) begin
				if (commit[i]) begin
					if (reg_lane_i[LANE_RESEN]) begin
						en_ff[i]     <= reg_wdata_i[EN_BIT];
						res_ff[i]    <= reg_wdata_i[RES_LSB +: RES_W];
						st_en_ff[i]  <= reg_wdata_i[EN_BIT];
						st_res_ff[i] <= reg_wdata_i[RES_LSB +: RES_W];
					end else begin
						en_ff[i]     <= st_en_ff[i];
						res_ff[i]    <= st_res_ff[i];
					end
					if (lane_rel) begin
						reload_ff[i] <= reg_wdata_i[RELOAD_LSB +: CNT_W];
					end
				end
			end
		end
	end

	// Prescalers
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < TIMER_NUM; i++) begin
				pre_ff[i] <= '0;
			end
		end else begin
			for (int i = 0; i < TIMER_NUM; i++) begin
				if (commit[i] || step[i]) begin
					pre_ff[i] <= '0;
				end else if (en_ff[i] && us_tick) begin
					pre_ff[i] <= pre_ff[i] + PRE_W'(1);
				end
			end
		end
	end

	// Down-counters
	always_comb begin
		for (int i = 0; i < TIMER_NUM; i++) begin
			nxt_count[i] = count_ff[i];
			if (commit[i]) begin
				nxt_count[i] = lane_rel ? reg_wdata_i[RELOAD_LSB +: CNT_W] : reload_ff[i];
			end else if (step[i] && (count_ff[i] != '0)) begin
				nxt_count[i] = count_ff[i] - CNT_W'(1);
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_ff[0] <= RST_COUNT0;
			count_ff[1] <= RST_COUNT1;
			timeout_ff  <= 2'h0;
		end else begin
			for (int i = 0; i < TIMER_NUM; i++) begin
				count_ff[i]   <= nxt_count[i];
				timeout_ff[i] <= (nxt_count[i] == '0);
			end
		end
	end
	assign timeout_o = timeout_ff;

	// Register reads
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_ff  <= 32'h0000_0000;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= reg_rd_i;
			if (reg_rd_i) begin
				unique case (reg_addr_i)
					CTL0_OFS:  rdata_ff <= {8'h00, st_en_ff[0], 3'h0, st_res_ff[0], reload_ff[0]};
					CTL1_OFS:  rdata_ff <= {8'h00, st_en_ff[1], 3'h0, st_res_ff[1], reload_ff[1]};
					STAT0_OFS: rdata_ff <= {16'h0000, count_ff[0]};
					STAT1_OFS: rdata_ff <= {16'h0000, count_ff[1]};
				endcase
			end
		end
	end
	assign reg_rdata_o  = rdata_ff;
	assign reg_rvalid_o = rvalid_ff;

	// Checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	sequence arm_seq;
		wr_ctl[0] && !armed_ff[0] && arm_ok;
	endsequence
	sequence commit_all_seq;
		commit[0] && (reg_lane_i == 4'hF);
	endsequence

	base_tick_a: assert property (us_tick |=> !us_tick [*8])
		else $error("base tick too frequent");
	arm_reject_a: assert property (
		wr_ctl[0] && !armed_ff[0] && reg_lane_i != 4'h1 |=> !armed_ff[0])
		else $error("armed with other lanes");
	arm_quiet_a: assert property (
		arm_seq |=> armed_ff[0] && $stable(en_ff[0]) && $stable(res_ff[0]))
		else $error("arming changed timer");
	second_disarm_a: assert property (wr_ctl[0] && armed_ff[0] |=> !armed_ff[0])
		else $error("still armed after second write");
	read_keeps_arm_a: assert property (reg_rd_i && !reg_wr_i |=> $stable(armed_ff))
		else $error("read changed arm state");
	bad_commit_a: assert property (
		wr_ctl[0] && armed_ff[0] && !key_ok
		|=> $stable(reload_ff[0]) && $stable(st_en_ff[0]) && $stable(en_ff[0]))
		else $error("bad key changed timer");
	enab_load_a: assert property (
		commit[0] && reg_lane_i[LANE_RESEN]
		|=> en_ff[0] == $past(reg_wdata_i[EN_BIT]) && st_en_ff[0] == en_ff[0])
		else $error("enable lane not loaded");
	reload_all_a: assert property (
		commit_all_seq ##1 !commit[0]
		|-> count_ff[0] == reload_ff[0]
		&& count_ff[0] == $past(reg_wdata_i[RELOAD_LSB +: CNT_W]))
		else $error("counter not loaded from bus");
	count_step_a: assert property (
		step[0] && !commit[0] && count_ff[0] != '0
		|=> count_ff[0] == $past(count_ff[0]) - CNT_W'(1))
		else $error("counter missed a step");
	zero_hold_a: assert property (
		count_ff[0] == '0 && !commit[0] |=> count_ff[0] == '0 && timeout_o[0])
		else $error("zero not held");
	status_read_a: assert property (
		reg_rd_i && reg_addr_i == STAT1_OFS
		|=> reg_rvalid_o && reg_rdata_o[15:0] == $past(count_ff[1]))
		else $error("status read wrong");
endmodule
`default_nettype wire

//--- testbench/dkwdt_top_tb.sv
/*
 Self-checking bench for the dual keyed watchdog timers.
 Assumes the design package, the 100 MHz clock and the default key values.
*/
`timescale 1ns/1ps
`default_nettype none
module dkwdt_top_tb import dkwdt_pkg::*;;
	localparam logic [7:0] KA = 8'h5A;
	localparam logic [7:0] KC = 8'hA5;
	logic             core_clk_i  = 1'b0;
	logic             rst_i       = 1'b1;
	logic             reg_wr_i    = 1'b0;
	logic             reg_rd_i    = 1'b0;
	logic [1:0]       reg_addr_i  = 2'h0;
	logic [3:0]       reg_lane_i  = 4'h0;
	logic [31:0]      reg_wdata_i = 32'h0;
	logic [31:0]      reg_rdata_o;
	logic             reg_rvalid_o;
	logic [1:0]       timeout_o;
	logic [31:0]      q;
	logic [31:0]      s = 32'hBD530055;
	logic [15:0]      rel;
	logic [3:0]       res;
	int               err_count = 0;
	int               samples_checked = 0;
	dkwdt_top #(.KEY_ARM(KA), .KEY_COMMIT(KC)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
		.reg_lane_i(reg_lane_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.reg_rvalid_o(reg_rvalid_o), .timeout_o(timeout_o));
	always #5 core_clk_i = ~core_clk_i;
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [31:0] ctl(input logic en, input logic [3:0] r, input logic [15:0] l);
		return {8'h00, en, 3'b000, r, l};
	endfunction
	function automatic logic cnt_ok(input logic [3:0] r, input logic [15:0] l,
		input logic [31:0] v);
		logic [31:0] lo;
		logic [31:0] hi;
		hi = {16'h0, l} - ((r == 4'h0) ? 32'h1 : 32'h0);
		lo = {16'h0, l} - ((r == 4'h0) ? 32'h2 : ((r == 4'h1) ? 32'h1 : 32'h0));
		return (v >= lo) && (v <= hi);
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [3:0] l, input logic [31:0] d);
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_lane_i = l;
		reg_wdata_i = d;
		@(posedge core_clk_i);
		#1 reg_wr_i = 1'b0;
		@(posedge core_clk_i);
		#1;
	endtask
	task automatic prog(input logic [1:0] a, input logic [3:0] l, input logic [31:0] d);
		wr(a, 4'h1, {KA, 24'h0});
		wr(a, l, d);
	endtask
	task automatic rd(input logic [1:0] a, output logic [31:0] v);
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		@(posedge core_clk_i);
		#1 reg_rd_i = 1'b0;
		chk("rvalid", 32'h1, {31'h0, reg_rvalid_o});
		v = reg_rdata_o;
		@(posedge core_clk_i);
		#1;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#300000;
		err_count++;
		wrap_up();
	end
	initial begin
		wait_cyc(10);
		rst_i = 1'b0;
		rd(2'h1, q); chk("cnt0", {16'h0, RST_COUNT0}, q);
		rd(2'h3, q); chk("cnt1", {16'h0, RST_COUNT1}, q);
		rd(2'h2, q); chk("ctl1 hi", 32'h0089, q >> 16);
		chk("tmo", 32'h0, {30'h0, timeout_o});
		// Wrong lanes, then wrong key: neither arms
		wr(2'h0, 4'h3, {KA, 24'h0});
		wr(2'h0, 4'hF, {KC, 8'h80, 16'd5});
		wr(2'h0, 4'h1, {KC, 24'h0});
		wr(2'h0, 4'hF, {KC, 8'h80, 16'd5});
		rd(2'h1, q); chk("bad arm", {16'h0, RST_COUNT0}, q);
		// Arm, reads in between, then full commit
		wr(2'h0, 4'h1, {KA, 24'h0});
		rd(2'h1, q); chk("arm idle", {16'h0, RST_COUNT0}, q);
		rd(2'h0, q);
		wr(2'h0, 4'hF, {KC, 8'h80, 16'd5});
		rd(2'h1, q); chk("commit cnt", 32'd5, q);
		rd(2'h0, q); chk("commit ctl", ctl(1'b1, 4'h0, 16'd5), q);
		wait_cyc(245); chk("early", 32'h0, {30'h0, timeout_o});
		wait_cyc(300); chk("expired", 32'h1, {30'h0, timeout_o});
		wait_cyc(200); rd(2'h1, q); chk("hold0", 32'h0, q);
		// Key lane only: reload from stored values
		prog(2'h0, 4'h1, {KC, 24'h0});
		rd(2'h1, q); chk("restore", 32'd5, q);
		chk("tmo clr", 32'h0, {30'h0, timeout_o});
		// Enable lane without both reload lanes, 2 us period
		prog(2'h0, 4'h7, {KC, 8'h81, 16'hFFFF});
		rd(2'h0, q); chk("res only", ctl(1'b1, 4'h1, 16'd5), q);
		rd(2'h1, q); chk("res cnt", 32'd5, q);
		wait_cyc(790); chk("2us early", 32'h0, {30'h0, timeout_o});
		wait_cyc(400); chk("2us end", 32'h1, {30'h0, timeout_o});
		// Commit without key lane disarms; a later commit is ignored
		wr(2'h0, 4'h1, {KA, 24'h0});
		wr(2'h0, 4'hE, {KC, 8'h80, 16'd9});
		wr(2'h0, 4'hF, {KC, 8'h80, 16'd9});
		rd(2'h1, q); chk("disarm", 32'h0, q);
		rd(2'h0, q); chk("disarm ctl", ctl(1'b1, 4'h1, 16'd5), q);
		// Stopped timer holds its count
		prog(2'h0, 4'hF, {KC, 8'h00, 16'd7});
		wait_cyc(300); rd(2'h1, q); chk("stopped", 32'd7, q);
		// Random programming of the second timer
		for (int i = 0; i < 8; i++) begin
			s = lfsr(s);
			rel = s[15:0] | 16'h0100;
			res = s[19:16];
			if (i == 0) res = 4'h0;
			if (i == 1) res = 4'hF;
			prog(2'h2, 4'hF, {KC, 4'h8, res, rel});
			rd(2'h2, q); chk("rnd ctl", ctl(1'b1, res, rel), q);
			wait_cyc(150);
			rd(2'h3, q);
			chk("rnd cnt", 32'h1, {31'h0, cnt_ok(res, rel, q)});
			rd(2'h1, q); chk("indep", 32'd7, q);
		end
		// Second timer expires on its own
		prog(2'h2, 4'hF, {KC, 8'h80, 16'd2});
		wait_cyc(300); chk("tmo1", 32'h2, {30'h0, timeout_o});
		wrap_up();
	end
endmodule
`default_nettype wire
